// ---- hdl/watchdog_with_write_guard.sv ----
// Guarded watchdog timer with Avalon-MM register slave.
//
// The placing of the registers and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps

// Summary of operation
// - One mode write accepted; further writes reset.
// - Stopped watchdog suppresses all access-fault resets.
// - Wrong key resets; restart key clears count.
// - Bit operation on key register resets.
// - Key register always reads back fixed value.
// - Unstoppable oscillator keeps counting through stop.
// - Stoppable oscillator halts count in standby.
// - Count resumes from held value, same clock.
// - Watchdog reset also clears watchdog itself.
// - Unstoppable oscillator forces low-speed count clock.
module watchdog_with_write_guard (
  input  wire logic                      mclk,
  input  wire logic                      resetn,
  input  wire logic [wd_pkg::ADDR_W-1:0] address,
  input  wire logic                      read,
  input  wire logic                      write,
  input  wire logic [31:0]               writedata,
  input  wire logic [3:0]                byteenable,
  output logic      [31:0]               readdata,
  output logic                           waitrequest,
  input  wire wd_pkg::standby_s          standby_in,
  output logic                           wdt_reset,
  output logic                           irq
);

  import wd_pkg::*;

  standby_s         sb;
  cfg_e             cfg;
  mode_s            mode;
  logic [7:0]       ls_div;
  logic             ls_tick;
  logic [CNT_W-1:0] count;
  logic             overflow;
  logic [EV_W-1:0]  irq_status;
  logic [EV_W-1:0]  irq_en;
  logic [EV_W-1:0]  events;
  logic [EV_W-1:0]  clr_mask;
  logic [EV_W-1:0]  next_status;
  logic             fire_wr;
  logic             fire_rd;
  logic             wr_byte;
  logic [7:0]       wbyte;
  logic             wr_mode;
  logic             wr_key;
  logic             key_ok;
  logic             key_bad;
  logic             key_bitop;
  logic             mode_second;
  logic             exempt;
  logic             violation;
  logic             running;
  logic             paused;
  logic             src_tick;
  logic             cnt_tick;
  logic             cnt_clear;
  logic             next_wdt_reset;
  logic [31:0]      next_readdata;

  ////////////////////////////////////////////////////////////////////////////

  wd_sync u_sync (
    .mclk   (mclk),
    .resetn (resetn),
    .d      (standby_in),
    .q      (sb)
  );

  wd_counter u_counter (
    .mclk     (mclk),
    .resetn   (resetn),
    .clear    (cnt_clear),
    .tick     (cnt_tick),
    .ovf_sel  (mode.ovf_sel),
    .count    (count),
    .overflow (overflow)
  );

  ////////////////////////////////////////////////////////////////////////////

  // Every access sees one wait cycle; it takes effect when waitrequest is low.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      waitrequest <= 1'b1;
    end else if ((read || write) && waitrequest) begin
      waitrequest <= 1'b0;
    end else begin
      waitrequest <= 1'b1;
    end
  end

  assign fire_wr = write && !waitrequest;
  assign fire_rd = read && !waitrequest;
  assign wr_byte = fire_wr && byteenable[0];
  assign wbyte   = writedata[7:0];
  assign wr_mode = wr_byte && (address == OFF_MODE);
  assign wr_key  = wr_byte && (address == OFF_KEY);

  always_comb begin
    next_readdata = 32'h0000_0000;
    case (address)
      OFF_MODE: begin
        next_readdata[7:0] = mode;
      end
      OFF_KEY: begin
        next_readdata[7:0] = KEY_READBACK;
      end
      OFF_STATE: begin
        next_readdata[CNT_W-1:0]    = count;
        next_readdata[ST_LOCKED_BIT] = (cfg == CFG_LOCKED);
        next_readdata[ST_STOP_BIT]   = !running;
        next_readdata[ST_PAUSE_BIT]  = paused;
      end
      OFF_IRQ_STAT: begin
        next_readdata[EV_W-1:0] = irq_status;
      end
      OFF_IRQ_EN: begin
        next_readdata[EV_W-1:0] = irq_en;
      end
      default: begin
        next_readdata = 32'h0000_0000;
      end
    endcase
  end

  // Read data is loaded in the wait cycle and stands at the accepting edge.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      readdata <= 32'h0000_0000;
    end else if (read && waitrequest) begin
      readdata <= next_readdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // The mode register locks after its first byte write.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cfg  <= CFG_OPEN;
      mode <= MODE_RESET;
    end else if (wdt_reset) begin
      cfg  <= CFG_OPEN;
      mode <= MODE_RESET;
    end else if (wr_mode && (cfg == CFG_OPEN)) begin
      cfg  <= CFG_LOCKED;
      mode <= wbyte;
    end
  end

  assign key_ok      = wr_key && (wbyte == KEY_RESTART);
  assign key_bad     = wr_key && (wbyte != KEY_RESTART);
  assign key_bitop   = wr_byte && (address == OFF_KEY_BITOP);
  assign mode_second = wr_mode && (cfg == CFG_LOCKED);

  // A watchdog stopped by the locked mode forgives all access faults.
  assign exempt    = (cfg == CFG_LOCKED) && mode.clk_hi
                     && !sb.unstoppable;
  assign violation = !exempt
                     && (mode_second || key_bad || key_bitop);

  ////////////////////////////////////////////////////////////////////////////

  // Low-speed oscillator modelled as a periodic tick of mclk.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ls_div <= 8'h00;
    end else if (ls_div == LS_DIV_M1) begin
      ls_div <= 8'h00;
    end else begin
      ls_div <= ls_div + 8'h01;
    end
  end

  assign ls_tick = (ls_div == LS_DIV_M1);

  always_comb begin
    if (sb.unstoppable) begin
      src_tick = ls_tick;
    end else if (mode.clk_lo) begin
      src_tick = 1'b1;
    end else begin
      src_tick = ls_tick;
    end
  end

  assign running   = sb.unstoppable || !mode.clk_hi;
  assign paused    = !sb.unstoppable && (sb.stop || sb.halt);
  // Pausing only gates the tick, so the count is held, not cleared.
  assign cnt_tick  = running && !paused && src_tick;
  assign cnt_clear = wdt_reset || key_ok;

  ////////////////////////////////////////////////////////////////////////////

  assign next_wdt_reset = overflow || violation;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wdt_reset <= 1'b0;
    end else begin
      wdt_reset <= next_wdt_reset;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    events              = '0;
    events[EV_OVF]      = overflow;
    events[EV_ILLEGAL]  = violation;
    events[EV_RESTART]  = key_ok;
  end

  assign clr_mask    = (wr_byte && (address == OFF_IRQ_CLR))
                       ? wbyte[EV_W-1:0] : '0;
  // A new event in the clearing cycle keeps its bit set.
  assign next_status = (irq_status & ~clr_mask) | events;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq_status <= '0;
    end else begin
      irq_status <= next_status;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq_en <= '0;
    end else if (wr_byte && (address == OFF_IRQ_EN)) begin
      irq_en <= wbyte[EV_W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_status & irq_en);
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  sequence reset_pulse_s;
    wdt_reset ##1 !wdt_reset;
  endsequence

  sequence self_cleared_s;
    (cfg == CFG_OPEN) && (count == '0) && (mode == MODE_RESET);
  endsequence

  property fault_resets_p(cause);
    cause |=> reset_pulse_s;
  endproperty

  overflow_reset_a: assert property (
    overflow |=> reset_pulse_s)
    else $error("Overflow did not raise one reset pulse");

  key_wrong_a: assert property (
    fault_resets_p(key_bad && !exempt))
    else $error("Wrong key did not raise a reset");

  key_restart_a: assert property (
    key_ok && !wdt_reset |=> (count == '0))
    else $error("Restart key did not clear the count");

  key_bitop_a: assert property (
    fault_resets_p(key_bitop && !exempt))
    else $error("Key bit operation did not raise a reset");

  second_write_a: assert property (
    wr_mode && (cfg == CFG_LOCKED) && !exempt |=> wdt_reset)
    else $error("Second mode write did not raise a reset");

  first_write_a: assert property (
    wr_mode && (cfg == CFG_OPEN) && !wdt_reset
    |=> (cfg == CFG_LOCKED) && (mode == $past(wbyte)))
    else $error("First mode write was not stored");

  stopped_quiet_a: assert property (
    exempt && !overflow |=> !wdt_reset)
    else $error("Stopped watchdog raised a reset");

  key_read_a: assert property (
    fire_rd && (address == OFF_KEY) |-> (readdata[7:0] == KEY_READBACK))
    else $error("Key register did not read back the fixed value");

  standby_hold_a: assert property (
    paused && !cnt_clear |=> (count == $past(count)))
    else $error("Count moved during standby");

  stop_counts_a: assert property (
    sb.unstoppable && sb.stop && ls_tick && !cnt_clear
    |=> (count != $past(count)))
    else $error("Count stalled in stop with unstoppable oscillator");

  ls_clock_a: assert property (
    sb.unstoppable && !ls_tick |=> (count == $past(count)) || $past(cnt_clear))
    else $error("Count advanced without a low-speed tick");

  self_reset_a: assert property (
    wdt_reset |=> self_cleared_s)
    else $error("Watchdog state survived its own reset");

  bus_wait_a: assert property (
    (read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("Bus access did not complete in one wait cycle");

  lock_holds_a: assert property (
    (cfg == CFG_LOCKED) && !wdt_reset
    |=> (cfg == CFG_LOCKED) && (mode == $past(mode)))
    else $error("Locked mode register changed");

  status_set_a: assert property (
    (events != '0) |=> ((irq_status & $past(events)) == $past(events)))
    else $error("Event did not set its status bit");

  status_clear_a: assert property (
    (clr_mask != '0)
    |=> ((irq_status & $past(clr_mask) & ~$past(events)) == '0))
    else $error("Status bit survived its clear");

  irq_level_a: assert property (
    1'b1 |=> (irq == |(irq_status & $past(irq_en))))
    else $error("Interrupt output does not follow enabled status");

endmodule

// ---- hdl/wd_counter.sv ----
// Watchdog up-counter with selectable overflow point.
`timescale 1ns/1ps
module wd_counter (
  input  wire logic                     mclk,
  input  wire logic                     resetn,
  input  wire logic                     clear,
  input  wire logic                     tick,
  input  wire logic [2:0]               ovf_sel,
  output logic      [wd_pkg::CNT_W-1:0] count,
  output logic                          overflow
);

  import wd_pkg::*;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      count <= '0;
    end else if (clear) begin
      count <= '0;
    end else if (tick) begin
      count <= count + CNT_W'(1);
    end
  end

  assign overflow = tick && !clear && (count == ovf_terminal(ovf_sel));

endmodule

// ---- hdl/wd_pkg.sv ----
// Constants, register map and carrier types for the guarded watchdog.
package wd_pkg;

  // Clock rates and the low-speed oscillator tick derived from mclk.
  localparam int          CLK_HZ     = 25_000_000;
  localparam int          LSOSC_HZ   = 240_000;
  localparam int          LS_DIV     = CLK_HZ / LSOSC_HZ;
  localparam logic [7:0]  LS_DIV_M1  = 8'(LS_DIV - 1);

  // Register map, byte addresses on the Avalon-MM slave.
  localparam int          ADDR_W        = 5;
  localparam logic [4:0]  OFF_MODE      = 5'h00;
  localparam logic [4:0]  OFF_KEY       = 5'h04;
  localparam logic [4:0]  OFF_KEY_BITOP = 5'h08;
  localparam logic [4:0]  OFF_STATE     = 5'h0c;
  localparam logic [4:0]  OFF_IRQ_STAT  = 5'h10;
  localparam logic [4:0]  OFF_IRQ_CLR   = 5'h14;
  localparam logic [4:0]  OFF_IRQ_EN    = 5'h18;

  // Key values and the mode register value after reset.
  localparam logic [7:0]  KEY_RESTART   = 8'hac;
  localparam logic [7:0]  KEY_READBACK  = 8'h9a;
  localparam logic [7:0]  MODE_RESET    = 8'h67;

  // Counter geometry: overflow at bit OVF_BASE plus the select field.
  localparam int          CNT_W         = 18;
  localparam int          OVF_BASE      = 10;

  // Field positions of the state register.
  localparam int          ST_LOCKED_BIT = 24;
  localparam int          ST_STOP_BIT   = 25;
  localparam int          ST_PAUSE_BIT  = 26;

  // Event bits of the interrupt status, clear and enable registers.
  localparam int          EV_OVF        = 0;
  localparam int          EV_ILLEGAL    = 1;
  localparam int          EV_RESTART    = 2;
  localparam int          EV_W          = 3;

  typedef struct packed {
    logic [2:0] fixed;
    logic       clk_hi;
    logic       clk_lo;
    logic [2:0] ovf_sel;
  } mode_s;

  typedef struct packed {
    logic unstoppable;
    logic stop;
    logic halt;
  } standby_s;

  typedef enum {CFG_OPEN, CFG_LOCKED} cfg_e;

  // Last count value before overflow for a given select field.
  function automatic logic [CNT_W-1:0] ovf_terminal(input logic [2:0] sel);
    return CNT_W'((CNT_W'(1) << (OVF_BASE + int'(sel))) - CNT_W'(1));
  endfunction

endpackage

// ---- hdl/wd_sync.sv ----
// Two-flop synchroniser for the standby and option inputs.
`timescale 1ns/1ps
module wd_sync (
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire wd_pkg::standby_s d,
  output wd_pkg::standby_s      q
);

  import wd_pkg::*;

  standby_s meta;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

// ---- verification/test_watchdog_with_write_guard.sv ----
// Self-checking register-level testbench for the guarded watchdog.
`timescale 1ns/1ps
module test_watchdog_with_write_guard;
  import wd_pkg::*;

  logic              mclk;
  logic              resetn;
  logic [ADDR_W-1:0] address;
  logic              read;
  logic              write;
  logic [31:0]       writedata;
  logic [3:0]        byteenable;
  logic [31:0]       readdata;
  logic              waitrequest;
  standby_s          standby_in;
  logic              wdt_reset;
  logic              irq;
  logic [31:0]       rst_count = 32'h0;
  logic [31:0]       exp_rst;
  logic [31:0]       q;
  logic [31:0]       a_cnt;
  int                err_count;
  int                checks;
  int                n;

  watchdog_with_write_guard u_dut (
    .mclk        (mclk),
    .resetn      (resetn),
    .address     (address),
    .read        (read),
    .write       (write),
    .writedata   (writedata),
    .byteenable  (byteenable),
    .readdata    (readdata),
    .waitrequest (waitrequest),
    .standby_in  (standby_in),
    .wdt_reset   (wdt_reset),
    .irq         (irq)
  );

  always #20 mclk = ~mclk;

  // Counts internal reset pulses so faults can be checked as deltas.
  always @(posedge mclk) begin
    if (wdt_reset === 1'b1) begin
      rst_count <= rst_count + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One Avalon-MM access; request is held until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [7:0] d, output logic [31:0] rdata);
    int k;
    @(posedge mclk);
    address   <= a;
    write     <= wr;
    read      <= !wr;
    writedata <= {24'h0, d};
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (waitrequest !== 1'b0 && k < 20);
    rdata = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0) begin
      err_count++;
      test_done();
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] rdata);
    bus(1'b0, a, 8'h00, rdata);
  endtask

  // Performs a write and expects the given number of reset pulses from it.
  task automatic fault(input logic [4:0] a, input logic [7:0] d,
                       input logic [31:0] pulses);
    wr(a, d);
    repeat (4) @(posedge mclk);
    exp_rst = exp_rst + pulses;
    check("wdt_reset pulses", rst_count, exp_rst);
  endtask

  task automatic do_reset();
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    resetn = 1'b0;
    address = '0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'hf;
    standby_in = standby_s'(3'b000);
    exp_rst = 32'h0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    check("waitrequest idle", {31'h0, waitrequest}, 32'h1);
    rd(OFF_KEY, q);
    check("key readback", q, {24'h0, KEY_READBACK});
    rd(OFF_MODE, q);
    check("mode reset", q, {24'h0, MODE_RESET});
    rd(5'h1c, q);
    check("unmapped read", q, 32'h0);
    $display("test reset_values done");

    wr(OFF_IRQ_EN, 8'h07);
    wr(OFF_MODE, 8'h68);
    fault(OFF_KEY, KEY_RESTART, 32'h0);
    rd(OFF_KEY, q);
    check("key readback after restart", q, {24'h0, KEY_READBACK});
    rd(OFF_IRQ_STAT, q);
    check("restart status", q, 32'h4);
    check("irq raised", {31'h0, irq}, 32'h1);
    wr(OFF_IRQ_EN, 8'h03);
    repeat (2) @(posedge mclk);
    check("irq masked", {31'h0, irq}, 32'h0);
    wr(OFF_IRQ_CLR, 8'h07);
    rd(OFF_IRQ_STAT, q);
    check("status cleared", q, 32'h0);
    wr(OFF_IRQ_EN, 8'h07);
    $display("test irq done");

    n = 0;
    while (wdt_reset !== 1'b1 && n < 1200) begin
      @(posedge mclk);
      n++;
    end
    check("overflow time", {31'h0, n >= 1000 && n <= 1030}, 32'h1);
    if (wdt_reset !== 1'b1) begin
      err_count++;
      test_done();
    end
    repeat (4) @(posedge mclk);
    exp_rst = exp_rst + 32'h1;
    rd(OFF_MODE, q);
    check("mode after wd reset", q, {24'h0, MODE_RESET});
    rd(OFF_STATE, q);
    check("lock after wd reset", {31'h0, q[ST_LOCKED_BIT]}, 32'h0);
    rd(OFF_IRQ_STAT, q);
    check("overflow status", q & 32'h1, 32'h1);
    wr(OFF_IRQ_CLR, 8'h07);
    $display("test overflow done");

    wr(OFF_MODE, 8'h68);
    fault(OFF_MODE, 8'h68, 32'h1);
    fault(OFF_KEY, 8'h55, 32'h1);
    fault(OFF_KEY_BITOP, 8'h01, 32'h1);
    rd(OFF_IRQ_STAT, q);
    check("illegal status", q & 32'h2, 32'h2);
    $display("test faults done");

    do_reset();
    wr(OFF_MODE, 8'h70);
    fault(OFF_MODE, 8'h68, 32'h0);
    fault(OFF_KEY_BITOP, 8'h01, 32'h0);
    fault(OFF_KEY, 8'h55, 32'h0);
    $display("test stopped_exempt done");

    for (int s = 0; s < 2; s++) begin
      do_reset();
      wr(OFF_MODE, 8'h68);
      wr(OFF_KEY, KEY_RESTART);
      repeat (200) @(posedge mclk);
      standby_in <= standby_s'(s == 0 ? 3'b001 : 3'b010);
      repeat (4) @(posedge mclk);
      rd(OFF_STATE, a_cnt);
      repeat (50) @(posedge mclk);
      rd(OFF_STATE, q);
      check("count held", {14'h0, q[17:0]}, {14'h0, a_cnt[17:0]});
      standby_in <= standby_s'(3'b000);
      repeat (10) @(posedge mclk);
      rd(OFF_STATE, q);
      check("count resumed", {31'h0, q[17:0] > a_cnt[17:0] &&
            q[17:0] < a_cnt[17:0] + 18'd30}, 32'h1);
    end
    $display("test standby_pause done");

    do_reset();
    standby_in <= standby_s'(3'b110);
    repeat (4) @(posedge mclk);
    wr(OFF_MODE, 8'h68);
    wr(OFF_KEY, KEY_RESTART);
    rd(OFF_STATE, a_cnt);
    repeat (1040) @(posedge mclk);
    rd(OFF_STATE, q);
    check("count in stop at slow rate", {31'h0, q[17:0] >= a_cnt[17:0] + 18'd9
          && q[17:0] <= a_cnt[17:0] + 18'd11}, 32'h1);
    fault(OFF_KEY, KEY_RESTART, 32'h0);
    rd(OFF_STATE, q);
    check("restart in stop", {31'h0, q[17:0] <= 18'd1}, 32'h1);
    $display("test unstoppable done");
    test_done();
  end
endmodule
